// File: verilog/peq_pkg.sv
package peq_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] BANK_A_OFS = 12'h040;
  localparam logic [ADDR_W-1:0] BANK_B_OFS = 12'h080;
  localparam logic [ADDR_W-1:0] WORD_BYTES = 12'h004;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_W = 2;
  localparam int CTRL_SHARE_BIT = 2;
  localparam int CTRL_MERGE_BIT = 3;
  localparam int CTRL_LINK_BIT = 4;
  localparam int CTRL_SHIFT_LSB = 8;
  localparam int CTRL_SHIFT_W = 3;

  // ****************************************
  // Status register fields
  // ****************************************
  localparam int STAT_EFF_LSB = 0;
  localparam int STAT_CONFLICT_BIT = 2;
  localparam int STAT_FULL_BIT = 3;
  localparam int STAT_OUT_BIT = 4;

  // ****************************************
  // Mode codes and filter geometry
  // ****************************************
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_EQ = 2'h2;
  localparam int TAPS = 9;
  localparam int CENTER = 4;
  localparam int CENTER_W = 18;
  localparam int NONCENTER_W = 12;
  localparam int FRAC_BITS = 16;
  localparam logic [2:0] SHIFT_MAX = 3'h6;

  typedef enum logic [1:0] {
    EFF_BYPASS,
    EFF_DUAL,
    EFF_SINGLE,
    EFF_TIMEVAR
  } peq_eff_e;

endpackage

// File: verilog/peq_fifo.sv
module peq_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  // Fill side
  input wire logic [WIDTH-1:0] s_data,
  input wire logic s_valid,
  output logic s_ready,
  // Drain side
  input wire logic m_ready,
  output logic [WIDTH-1:0] m_data,
  output logic m_valid
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("peq_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
    logic in_ready;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } peq_fifo_s;

  peq_fifo_s s;
  peq_fifo_s next_s;
  logic push;
  logic pop;

  // Output word sits in its own register so the drain side sees flop outputs
  always_comb begin
    next_s = s;
    push = s_valid && s.in_ready;
    pop = (s.count != '0) && (!s.out_valid || m_ready);
    if (push) begin
      next_s.mem[s.wr_ptr] = s_data;
      next_s.wr_ptr = s.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_s.out_data = s.mem[s.rd_ptr];
      next_s.out_valid = 1'b1;
      next_s.rd_ptr = s.rd_ptr + 1'b1;
    end else if (m_ready) begin
      next_s.out_valid = 1'b0;
    end
    next_s.count = s.count + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};
    next_s.in_ready = next_s.count < (PTR_W + 1)'(DEPTH);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else if (en) begin
      s <= next_s;
    end
  end

  assign s_ready = s.in_ready;
  assign m_valid = s.out_valid;
  assign m_data = s.out_data;

endmodule

// File: verilog/peq_equalizer.sv
// Our own choices: the APB interface to the registers and the register addresses.
module peq_equalizer #(
  parameter int SAMPLE_W = 8,
  parameter int FIFO_DEPTH = 8
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [peq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter sample input, sample a precedes sample b in merged operation
  input wire logic [SAMPLE_W-1:0] smp_a,
  input wire logic [SAMPLE_W-1:0] smp_b,
  input wire logic smp_valid,
  output logic smp_ready,
  // Equalized output toward the formatter
  input wire logic eq_ready,
  output logic [SAMPLE_W-1:0] eq_a,
  output logic [SAMPLE_W-1:0] eq_b,
  output logic eq_valid
);

  localparam int CW = peq_pkg::CENTER_W;
  localparam int HIST = peq_pkg::TAPS - 1;
  localparam int ACC_W = SAMPLE_W + CW + 12;

  initial begin
    if (SAMPLE_W < 2 || SAMPLE_W > 16) begin
      $error("peq_equalizer: SAMPLE_W must lie between 2 and 16");
    end
    if (FIFO_DEPTH < 2) begin
      $error("peq_equalizer: FIFO_DEPTH must be at least 2");
    end
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0] mode;
    logic share;
    logic merge;
    logic link_single;
    logic [2:0] shift;
    logic [peq_pkg::TAPS-1:0][CW-1:0] bank_a;
    logic [peq_pkg::TAPS-1:0][CW-1:0] bank_b;
    logic [HIST-1:0][SAMPLE_W-1:0] hist_a;
    logic [HIST-1:0][SAMPLE_W-1:0] hist_b;
    logic [HIST-1:0][SAMPLE_W-1:0] merged;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } peq_state_s;

  peq_state_s s;
  peq_state_s next_s;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic coef_hit(input logic [peq_pkg::ADDR_W-1:0] addr,
                                    input logic [peq_pkg::ADDR_W-1:0] base);
    logic [peq_pkg::ADDR_W-1:0] top;
    top = base + peq_pkg::ADDR_W'(peq_pkg::TAPS * 4);
    return (addr >= base) && (addr < top) && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic [3:0] coef_index(input logic [peq_pkg::ADDR_W-1:0] addr,
                                            input logic [peq_pkg::ADDR_W-1:0] base);
    logic [peq_pkg::ADDR_W-1:0] diff;
    diff = (addr - base) >> 2;
    return diff[3:0];
  endfunction

  // Accumulates at the center tap scale; non-center products are lifted by the
  // spare shift so one adder serves every weight setting
  function automatic logic [SAMPLE_W-1:0] fir(input logic [peq_pkg::TAPS-1:0][SAMPLE_W-1:0] win,
                                              input logic [peq_pkg::TAPS-1:0][CW-1:0] cf,
                                              input logic [2:0] shift);
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] term;
    logic signed [ACC_W-1:0] lim_hi;
    logic signed [ACC_W-1:0] lim_lo;
    logic [2:0] lift;
    acc = '0;
    lift = peq_pkg::SHIFT_MAX - shift;
    lim_hi = ACC_W'((1 <<< (SAMPLE_W - 1)) - 1);
    lim_lo = -(ACC_W'(1 <<< (SAMPLE_W - 1)));
    for (int k = 0; k < peq_pkg::TAPS; k++) begin
      if (k == peq_pkg::CENTER) begin
        term = ACC_W'($signed(win[k]) * $signed(cf[k]));
      end else begin
        term = ACC_W'($signed(win[k]) * $signed(cf[k][peq_pkg::NONCENTER_W-1:0]));
        term = term <<< lift;
      end
      acc = acc + term;
    end
    acc = acc + ACC_W'(1 <<< (peq_pkg::FRAC_BITS - 1));
    acc = acc >>> peq_pkg::FRAC_BITS;
    if (acc > lim_hi) begin
      acc = lim_hi;
    end else if (acc < lim_lo) begin
      acc = lim_lo;
    end
    return acc[SAMPLE_W-1:0];
  endfunction

  // ****************************************
  // Mode decode
  // ****************************************
  peq_pkg::peq_eff_e eff;
  logic conflict;

  // Illegal flag mixes and a link mode that cannot carry the setting fall back
  // to bypass rather than emit a filter built for the wrong sample order
  always_comb begin
    eff = peq_pkg::EFF_BYPASS;
    conflict = 1'b0;
    if (s.mode == peq_pkg::MODE_EQ) begin
      if (!s.share && !s.merge) begin
        if (!s.link_single) begin
          eff = peq_pkg::EFF_DUAL;
        end else begin
          conflict = 1'b1;
        end
      end else if (s.share && s.merge) begin
        if (s.link_single) begin
          eff = peq_pkg::EFF_SINGLE;
        end else begin
          conflict = 1'b1;
        end
      end else if (!s.share && s.merge) begin
        if (s.link_single) begin
          eff = peq_pkg::EFF_TIMEVAR;
        end else begin
          conflict = 1'b1;
        end
      end else begin
        conflict = 1'b1;
      end
    end else if (s.mode != peq_pkg::MODE_OFF) begin
      conflict = 1'b1;
    end
  end

  // ****************************************
  // Data path
  // ****************************************
  logic fifo_ready;
  logic accept;
  logic [SAMPLE_W-1:0] res_a;
  logic [SAMPLE_W-1:0] res_b;
  logic [peq_pkg::TAPS-1:0][SAMPLE_W-1:0] win_da;
  logic [peq_pkg::TAPS-1:0][SAMPLE_W-1:0] win_db;
  logic [peq_pkg::TAPS-1:0][SAMPLE_W-1:0] win_ma;
  logic [peq_pkg::TAPS-1:0][SAMPLE_W-1:0] win_mb;

  assign accept = smp_valid && fifo_ready;
  // Index 0 is the newest sample; merged windows interleave a before b
  assign win_da = {s.hist_a, smp_a};
  assign win_db = {s.hist_b, smp_b};
  assign win_ma = {s.merged, smp_a};
  assign win_mb = {s.merged[HIST-2:0], smp_a, smp_b};

  always_comb begin
    unique case (eff)
      peq_pkg::EFF_BYPASS: begin
        res_a = smp_a;
        res_b = smp_b;
      end
      peq_pkg::EFF_DUAL: begin
        res_a = fir(win_da, s.bank_a, s.shift);
        res_b = fir(win_db, s.bank_b, s.shift);
      end
      peq_pkg::EFF_SINGLE: begin
        res_a = fir(win_ma, s.bank_a, s.shift);
        res_b = fir(win_mb, s.bank_a, s.shift);
      end
      peq_pkg::EFF_TIMEVAR: begin
        res_a = fir(win_ma, s.bank_a, s.shift);
        res_b = fir(win_mb, s.bank_b, s.shift);
      end
    endcase
  end

  peq_fifo #(
    .WIDTH(2 * SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rst(rst),
    .en(ce),
    .s_data({res_b, res_a}),
    .s_valid(smp_valid),
    .s_ready(fifo_ready),
    .m_ready(eq_ready),
    .m_data({eq_b, eq_a}),
    .m_valid(eq_valid)
  );

  assign smp_ready = fifo_ready;

  // ****************************************
  // Register access
  // ****************************************
  logic ctrl_hit;
  logic stat_hit;
  logic a_hit;
  logic b_hit;
  logic [3:0] a_idx;
  logic [3:0] b_idx;
  logic [31:0] rd_val;
  logic [2:0] wr_shift;

  assign ctrl_hit = (paddr == peq_pkg::CTRL_OFS);
  assign stat_hit = (paddr == peq_pkg::STATUS_OFS);
  assign a_hit = coef_hit(paddr, peq_pkg::BANK_A_OFS);
  assign b_hit = coef_hit(paddr, peq_pkg::BANK_B_OFS);
  assign a_idx = coef_index(paddr, peq_pkg::BANK_A_OFS);
  assign b_idx = coef_index(paddr, peq_pkg::BANK_B_OFS);
  assign wr_shift = pwdata[peq_pkg::CTRL_SHIFT_LSB +: peq_pkg::CTRL_SHIFT_W];

  always_comb begin
    rd_val = '0;
    if (ctrl_hit) begin
      rd_val[peq_pkg::CTRL_MODE_LSB +: peq_pkg::CTRL_MODE_W] = s.mode;
      rd_val[peq_pkg::CTRL_SHARE_BIT] = s.share;
      rd_val[peq_pkg::CTRL_MERGE_BIT] = s.merge;
      rd_val[peq_pkg::CTRL_LINK_BIT] = s.link_single;
      rd_val[peq_pkg::CTRL_SHIFT_LSB +: peq_pkg::CTRL_SHIFT_W] = s.shift;
    end else if (stat_hit) begin
      rd_val[peq_pkg::STAT_EFF_LSB +: 2] = eff;
      rd_val[peq_pkg::STAT_CONFLICT_BIT] = conflict;
      rd_val[peq_pkg::STAT_FULL_BIT] = !fifo_ready;
      rd_val[peq_pkg::STAT_OUT_BIT] = eq_valid;
    end else if (a_hit) begin
      rd_val = 32'($signed(s.bank_a[a_idx]));
    end else if (b_hit) begin
      rd_val = 32'($signed(s.bank_b[b_idx]));
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  // One wait state: data is set up on the first access cycle, and a write
  // lands on the edge where pready is seen high
  always_comb begin
    next_s = s;
    if (accept) begin
      next_s.hist_a = {s.hist_a[HIST-2:0], smp_a};
      next_s.hist_b = {s.hist_b[HIST-2:0], smp_b};
      next_s.merged = {s.merged[HIST-3:0], smp_a, smp_b};
    end
    if (psel && penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !(ctrl_hit || stat_hit || a_hit || b_hit);
      next_s.prdata = rd_val;
    end else if (psel && penable) begin
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
      if (pwrite && !s.pslverr) begin
        if (ctrl_hit) begin
          next_s.mode = pwdata[peq_pkg::CTRL_MODE_LSB +: peq_pkg::CTRL_MODE_W];
          next_s.share = pwdata[peq_pkg::CTRL_SHARE_BIT];
          next_s.merge = pwdata[peq_pkg::CTRL_MERGE_BIT];
          next_s.link_single = pwdata[peq_pkg::CTRL_LINK_BIT];
          next_s.shift = (wr_shift > peq_pkg::SHIFT_MAX) ? peq_pkg::SHIFT_MAX : wr_shift;
        end else if (a_hit) begin
          next_s.bank_a[a_idx] = pwdata[CW-1:0];
        end else if (b_hit) begin
          next_s.bank_b[b_idx] = pwdata[CW-1:0];
        end
      end
    end else begin
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;

endmodule

// File: dv/peq_properties.sv
module peq_equalizer_checker #(
  parameter int SAMPLE_W = 8,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [peq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sample streams
  input wire logic [SAMPLE_W-1:0] smp_a,
  input wire logic [SAMPLE_W-1:0] smp_b,
  input wire logic smp_valid,
  input wire logic smp_ready,
  input wire logic eq_ready,
  input wire logic [SAMPLE_W-1:0] eq_a,
  input wire logic [SAMPLE_W-1:0] eq_b,
  input wire logic eq_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Shadow of the control word and of the words in flight
  // ****
  logic [31:0] ctrl_q;
  logic [7:0] occ;
  logic live_q, acc, del, mapped;
  logic [1:0] eff;
  assign acc = smp_valid && smp_ready && ce;
  assign del = eq_valid && eq_ready && ce;
  assign mapped = paddr == peq_pkg::CTRL_OFS || paddr == peq_pkg::STATUS_OFS || (paddr[1:0] == 2'h0
    && ((paddr >= 12'h040 && paddr <= 12'h060) || (paddr >= 12'h080 && paddr <= 12'h0A0)));
  // Bits 4:2 are link, merge, share
  assign eff = ctrl_q[1:0] != peq_pkg::MODE_EQ ? 2'h0 : ctrl_q[4:2] == 3'h0 ? 2'h1 :
    ctrl_q[4:2] == 3'h7 ? 2'h2 : ctrl_q[4:2] == 3'h6 ? 2'h3 : 2'h0;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= 32'h0;
      occ <= 8'h0;
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
      occ <= occ + 8'(acc) - 8'(del);
      if (psel && penable && pready && pwrite && paddr == peq_pkg::CTRL_OFS) begin
        ctrl_q <= pwdata;
      end
    end
  end
  // ****
  // Properties
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  apb_one_wait_a:
    assert property ($rose(penable) && psel && ce |-> !pready ##1 pready) else $error("apb wait state wrong");
  ready_pulse_a:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
  err_unmapped_a:
    assert property (pready |-> pslverr == !mapped) else $error("pslverr does not match address map");
  status_mode_a:
    assert property (pready && !pwrite && paddr == peq_pkg::STATUS_OFS |-> prdata[1:0] == eff)
      else $error("effective mode wrong");
  status_conflict_a:
    assert property (pready && !pwrite && paddr == peq_pkg::STATUS_OFS |->
      prdata[2] == (ctrl_q[1:0] != peq_pkg::MODE_OFF && eff == 2'h0)) else $error("conflict flag wrong");
  bypass_pass_a:
    assert property (acc && occ == 8'h0 && ctrl_q[1:0] == peq_pkg::MODE_OFF |->
      ##2 eq_valid && eq_a == $past(smp_a, 2) && eq_b == $past(smp_b, 2)) else $error("bypass altered data");
  out_hold_a:
    assert property (eq_valid && !eq_ready |=> eq_valid && $stable(eq_a) && $stable(eq_b))
      else $error("output dropped before taken");
  no_phantom_a:
    assert property (eq_valid |-> occ != 8'h0) else $error("output without input");
  empty_ready_a:
    assert property (live_q && occ == 8'h0 |-> smp_ready) else $error("empty pipe refuses input");
  refuse_full_a:
    assert property (live_q && !smp_ready |-> occ >= FIFO_DEPTH) else $error("input refused before full");
  cover property (del && occ == 8'h1);
  cover property (pready && pslverr);
  cover property (live_q && !smp_ready);
endmodule

bind peq_equalizer peq_equalizer_checker #(.SAMPLE_W(SAMPLE_W), .FIFO_DEPTH(FIFO_DEPTH)) i_chk (
  .core_clk(core_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .smp_a(smp_a), .smp_b(smp_b), .smp_valid(smp_valid), .smp_ready(smp_ready),
  .eq_ready(eq_ready), .eq_a(eq_a), .eq_b(eq_b), .eq_valid(eq_valid));

// File: dv/peq_sink.sv
module peq_sink #(
  parameter int SAMPLE_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Equalized stream and pacing
  input wire logic [SAMPLE_W-1:0] eq_a,
  input wire logic [SAMPLE_W-1:0] eq_b,
  input wire logic eq_valid,
  input wire logic [1:0] stall,
  output logic eq_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [SAMPLE_W-1:0] got_a[$];
  logic [SAMPLE_W-1:0] got_b[$];
  logic ph;
  // Pacing 0 takes every word, 1 holds off, 2 takes every other cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      eq_ready <= 1'b0;
      ph <= 1'b0;
    end else begin
      if (eq_valid && eq_ready) begin
        got_a.push_back(eq_a);
        got_b.push_back(eq_b);
      end
      ph <= !ph;
      eq_ready <= stall == 2'h0 || (stall == 2'h2 && ph);
    end
  end
endmodule

// File: dv/test_programmable_equalizer_fir.sv
module test_programmable_equalizer_fir;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] smp_a = 8'h00, smp_b = 8'h00, eq_a, eq_b;
  logic smp_valid = 1'b0, smp_ready, eq_ready, eq_valid;
  logic [1:0] stall = 2'h0;
  logic [7:0] ex_a[$], ex_b[$];
  int bad_count = 0, n_compared = 0, cycles = 0, cur = 0, sh = 1, seq = 0, took;
  int ha[9], hb[9], hm[9];
  int ca[9] = '{0, 32'h400, 0, 0, 32'h8000, 0, 0, 0, 0};
  int cb[9] = '{0, 0, 0, 0, 32'h30000, 0, 0, 0, 32'hFC0};

  always #50 core_clk = ~core_clk;

  peq_equalizer #(.SAMPLE_W(8), .FIFO_DEPTH(8)) i_dut (.core_clk(core_clk), .rst(rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .smp_a(smp_a), .smp_b(smp_b), .smp_valid(smp_valid),
    .smp_ready(smp_ready), .eq_ready(eq_ready), .eq_a(eq_a), .eq_b(eq_b), .eq_valid(eq_valid));
  peq_sink #(.SAMPLE_W(8)) i_sink (.clk(core_clk), .rst(rst), .eq_a(eq_a), .eq_b(eq_b),
    .eq_valid(eq_valid), .stall(stall), .eq_ready(eq_ready));

  // ****
  // Shared bus, stream and reference helpers
  // ****
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      $display("BAD run length expected below %0d seen %0d", 30000, cycles);
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the run timeout ends this wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic void push(ref int h[9], input int v);
    for (int k = 8; k > 0; k--) h[k] = h[k-1];
    h[0] = v;
  endfunction

  // Coefficients are kept exact so that rounding never decides a result
  function automatic int fir(int h[9], int c[9]);
    int s;
    s = 0;
    for (int k = 0; k < 9; k++) begin
      if (k == 4) s += h[k] * ((c[k] <<< 14) >>> 14);
      else s += h[k] * ((c[k] <<< 20) >>> 20) * (1 << (6 - sh));
    end
    s = (s + 32768) >>> 16;
    return s > 127 ? 127 : (s < -128 ? -128 : s);
  endfunction

  task automatic send(input int i, input int lim, output bit ok);
    int a, b, ya, yb, k;
    a = 32 * ((i * 3) % 8) - 128;
    b = 32 * ((i * 5 + 1) % 8) - 128;
    smp_a <= a[7:0];
    smp_b <= b[7:0];
    smp_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (smp_ready !== 1'b1 && k < lim);
    ok = smp_ready === 1'b1;
    if (ok) begin
      push(ha, a);
      push(hb, b);
      push(hm, a);
      if (cur == 0) ya = a;
      else if (cur == 1) ya = fir(ha, ca);
      else ya = fir(hm, ca);
      push(hm, b);
      if (cur == 0) yb = b;
      else if (cur == 1) yb = fir(hb, cb);
      else yb = fir(hm, cur == 2 ? ca : cb);
      ex_a.push_back(ya[7:0]);
      ex_b.push_back(yb[7:0]);
    end
  endtask

  task automatic run(input logic [31:0] ctrl, input int e, input int n, input logic [1:0] st);
    bit ok;
    int k;
    apb(1'b1, peq_pkg::CTRL_OFS, ctrl);
    cur = e;
    stall <= st;
    took = 0;
    for (int j = 0; j < n; j++) begin
      send(seq, st == 2'h1 ? 6 : 1000, ok);
      if (!ok) begin
        // Refused beat stays offered: look at status, then let the sink drain
        apb(1'b0, peq_pkg::STATUS_OFS, 32'h0);
        chk("status when full", 32'h18 + cur, rd);
        st = 2'h0;
        stall <= 2'h0;
        send(seq, 1000, ok);
      end else if (st == 2'h1) begin
        took++;
      end
      seq++;
    end
    smp_valid <= 1'b0;
    stall <= 2'h0;
    k = 0;
    while (i_sink.got_a.size() < ex_a.size() && k < 3000) begin
      @(posedge core_clk);
      k++;
    end
    while (ex_a.size() > 0 && i_sink.got_a.size() > 0) begin
      chk("eq_a", ex_a.pop_front(), i_sink.got_a.pop_front());
      chk("eq_b", ex_b.pop_front(), i_sink.got_b.pop_front());
    end
    chk("words missing", 0, ex_a.size());
    chk("words extra", 0, i_sink.got_a.size());
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    apb(1'b0, peq_pkg::CTRL_OFS, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped read err", 32'h1, er);
    chk("unmapped read data", 32'h0, rd);
    apb(1'b1, 12'h0C0, 32'h1);
    chk("unmapped write err", 32'h1, er);
    apb(1'b1, peq_pkg::STATUS_OFS, 32'hF);
    chk("status write err", 32'h0, er);
    apb(1'b1, peq_pkg::CTRL_OFS, 32'h700);
    apb(1'b0, peq_pkg::CTRL_OFS, 32'h0);
    chk("shift clamp", 32'h600, rd);
    apb(1'b0, peq_pkg::STATUS_OFS, 32'h0);
    chk("status kept", 32'h0, rd);
    for (int k = 0; k < 9; k++) begin
      apb(1'b1, peq_pkg::BANK_A_OFS + 12'(4 * k), ca[k]);
      apb(1'b1, peq_pkg::BANK_B_OFS + 12'(4 * k), cb[k]);
    end
    apb(1'b0, peq_pkg::BANK_A_OFS + 12'h010, 32'h0);
    chk("center a", 32'h00008000, rd);
    apb(1'b0, peq_pkg::BANK_B_OFS + 12'h010, 32'h0);
    chk("center b", 32'hFFFF0000, rd);
  endtask

  // Clock enable low must hold a transfer in its wait state
  task automatic t_freeze();
    @(posedge core_clk);
    ce <= 1'b0;
    psel <= 1'b1;
    pwrite <= 1'b0;
    paddr <= peq_pkg::CTRL_OFS;
    @(posedge core_clk);
    penable <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("frozen pready", 32'h0, pready);
    ce <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    chk("thawed read", 32'h600, prdata);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_modes();
    logic [31:0] c[7] = '{32'h00C, 32'h002, 32'h01E, 32'h01A, 32'h012, 32'h003, 32'h006};
    int e[7] = '{0, 1, 2, 3, 0, 0, 0};
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, peq_pkg::CTRL_OFS, c[i]);
      apb(1'b0, peq_pkg::STATUS_OFS, 32'h0);
      chk("effective mode", e[i], rd[1:0]);
      chk("conflict", i >= 4, rd[2]);
    end
  endtask

  task automatic t_full_dual();
    run(32'h102, 1, 14, 2'h1);
    chk("beats before refusal", 32'h1, took >= 8 && took < 14);
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_freeze();
    t_modes();
    run(32'h10C, 0, 6, 2'h0);
    t_full_dual();
    run(32'h11E, 2, 12, 2'h2);
    run(32'h11A, 3, 12, 2'h0);
    complete_run();
  end
endmodule
